/* include/lvpm_pkg.sv */
// Purpose: constants and types of the low voltage and power mode block
// Assumes: pclk at 100 MHz, apb with 32-bit data
// Notes: Notes on behaviour below
// Notes on behaviour
// RULE1 - options may exclude detector or low-voltage reset
// RULE2 - mode bit 3 switches detector on
// RULE3 - mode bit 5 reads detector result only
// RULE4 - mode bit 2 gates internal clock in halt
// RULE5 - mode bits 0,1,4,6,7 are unused
// RULE6 - low-voltage reset ORed with external reset
// RULE7 - power down disables detector and reset
// RULE8 - reset only after low supply over 1ms
// RULE9 - hold 1024 clocks after reset release
// RULE10 - normal, idle and halt modes; normal runs oscillator
// RULE11 - halt with gate bit 0 enters idle
// RULE12 - gate 1, watchdog on: halt, oscillator runs
// RULE13 - gate 1, watchdog off: halt, oscillator off
// RULE14 - internal oscillator off unless watchdog osc selected
// RULE15 - synchronise async indications before use
package lvpm_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 10;
  // persistence of low supply before reset, in ns
  localparam int LVR_PERSIST_NS = 1000000;
  // least time rounds up to whole cycles
  localparam int LVR_PERSIST_CYC = (LVR_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LVR_CNT_W = 17;
  // settle delay in system clocks
  localparam int SETTLE_CYC = 1024;
  localparam int SETTLE_W = 11;
  // register indices and byte addresses
  localparam logic [9:0] MODE_INDEX = 10'h009;
  localparam logic [9:0] STATUS_INDEX = 10'h00a;
  localparam logic [11:0] MODE_ADDR = {MODE_INDEX, 2'b00};
  localparam logic [11:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};
  // mode register field positions
  localparam int GATE_BIT = 2;
  localparam int DET_EN_BIT = 3;
  localparam int DET_RES_BIT = 5;
  // reset values
  localparam logic MODE_GATE_RST = 1'b0;
  localparam logic MODE_DET_EN_RST = 1'b0;
  // synchroniser lanes
  localparam int SYNC_W = 7;
  localparam int SY_RESET_N = 0;
  localparam int SY_LVD_LOW = 1;
  localparam int SY_LVR_LOW = 2;
  localparam int SY_OPT_DET = 3;
  localparam int SY_OPT_RST = 4;
  localparam int SY_OPT_WDT = 5;
  localparam int SY_OPT_WOSC = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h00;
  // operating modes
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IDLE, MODE_HALT} lvpm_mode_type;
endpackage : lvpm_pkg

/* include/lvpm_sync_if.sv */
// Purpose: carries raw and cleaned asynchronous levels
// Assumes: one clock domain on the clean side
// Notes: raw side written by the top, clean side by the synchroniser
`timescale 1ns/10ps
interface lvpm_sync_if;
  import lvpm_pkg::*;
  logic [SYNC_W-1:0] raw; // levels from pins and analog comparators
  logic [SYNC_W-1:0] clean; // agreed, synchronised levels
  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface : lvpm_sync_if

/* hdl/lvpm_sync.sv */
// Purpose: three-flop synchroniser with agreement filter
// Assumes: raw levels may change at any time
// Notes: a change counts once second and third flop agree
`timescale 1ns/10ps
module lvpm_sync (
  input wire logic pclk,
  input wire logic presetn,
  lvpm_sync_if.sync_side sif
);
  import lvpm_pkg::*;

  // whole state of the synchroniser
  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] clean;
  } lvpm_sync_type;

  lvpm_sync_type st;
  lvpm_sync_type next_st;

  // next state: first flop only feeds the second
  always_comb begin
    next_st = st;
    next_st.s1 = sif.raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < SYNC_W; i++) begin
      // lane updates only where second and third agree
      if (st.s2[i] == st.s3[i]) begin
        next_st.clean[i] = st.s3[i]; // RULE15
      end
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST};
    end else begin
      st <= next_st;
    end
  end

  assign sif.clean = st.clean;

  property p_sync_agree;
    @(posedge pclk) disable iff (!presetn)
    (st.s2 == st.s3) |=> (st.clean == $past(st.s3));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("clean level missed agreed value"); // RULE15
endmodule : lvpm_sync

/* hdl/lvpm_top.sv */
// Purpose: low voltage supervision, reset combining and power modes
// Assumes: apb slave, pclk 100 MHz, async level inputs from analog parts
// Notes: zero-wait apb; unused mode bits read zero
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
module lvpm_top #(
  // cycles of low supply tolerated before reset
  parameter int LVR_PERSIST_CYCLES = lvpm_pkg::LVR_PERSIST_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic lvd_low_in,
  input wire logic lvr_low_in,
  input wire logic opt_detector_include,
  input wire logic opt_reset_include,
  input wire logic opt_watchdog_enable,
  input wire logic watchdog_osc_select,
  input wire logic halt_exec,
  input wire logic wake_event,
  output logic chip_reset,
  output logic startup_hold,
  output logic detector_on,
  output logic ext_osc_on,
  output logic sys_clock_run,
  output logic internal_rc_clock_en,
  output logic internal_rc_osc_on,
  output lvpm_pkg::lvpm_mode_type op_mode
);
  import lvpm_pkg::*;

  // persistence limit at counter width
  localparam logic [LVR_CNT_W-1:0] LVR_LIMIT = LVR_CNT_W'(LVR_PERSIST_CYCLES);
  // last settle count before release
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

  // whole state of the block
  typedef struct packed {
    lvpm_mode_type mode; // operating mode
    logic gate; // halt clock gate bit
    logic det_en; // detector enable bit
    logic det_result; // latched detector result
    logic [LVR_CNT_W-1:0] lvr_cnt; // low supply duration
    logic lvr_trip; // low-voltage reset active
    logic [SETTLE_W-1:0] settle_cnt; // startup settle timer
    logic hold; // settle in progress
    logic [31:0] rdata; // read data register
  } lvpm_state_type;

  lvpm_state_type st;
  lvpm_state_type next_st;

  // carrier to the synchroniser
  lvpm_sync_if sif ();

  // cleaned levels
  logic ext_reset; // external reset asserted
  logic lvd_low; // detector sees low supply
  logic lvr_low; // supply in the reset band
  logic opt_det; // detector option included
  logic opt_rst; // reset option included
  logic opt_wdt; // watchdog enabled
  logic opt_wosc; // watchdog oscillator selected

  // derived controls
  logic normal; // normal mode
  logic det_active; // detector powered
  logic lvr_active; // reset monitor powered
  logic wr_access; // write completes this edge
  logic rd_setup; // read setup cycle
  logic addr_hit; // address maps to a register

  // feed raw levels into the synchroniser: one process drives the whole lane vector
  always_comb begin
    sif.raw = SYNC_RST; // every lane written below
    sif.raw[SY_RESET_N] = external_reset_pin_n;
    sif.raw[SY_LVD_LOW] = lvd_low_in;
    sif.raw[SY_LVR_LOW] = lvr_low_in;
    sif.raw[SY_OPT_DET] = opt_detector_include;
    sif.raw[SY_OPT_RST] = opt_reset_include;
    sif.raw[SY_OPT_WDT] = opt_watchdog_enable;
    sif.raw[SY_OPT_WOSC] = watchdog_osc_select;
  end

  // all asynchronous levels pass three flops
  lvpm_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .sif(sif)
  );

  // unpack cleaned levels
  assign ext_reset = !sif.clean[SY_RESET_N];
  assign lvd_low = sif.clean[SY_LVD_LOW]; // RULE15
  assign lvr_low = sif.clean[SY_LVR_LOW]; // RULE15
  assign opt_det = sif.clean[SY_OPT_DET];
  assign opt_rst = sif.clean[SY_OPT_RST];
  assign opt_wdt = sif.clean[SY_OPT_WDT];
  assign opt_wosc = sif.clean[SY_OPT_WOSC];

  // mode decode
  assign normal = (st.mode == MODE_NORMAL);
  // detector only when included, enabled and not powered down
  assign det_active = opt_det && st.det_en && normal; // RULE1 RULE2 RULE7
  // reset monitor only when included and not powered down
  assign lvr_active = opt_rst && normal; // RULE1 RULE7

  // either source gives the same chip reset
  assign chip_reset = ext_reset || st.lvr_trip; // RULE6

  // apb decode
  assign addr_hit = (paddr == MODE_ADDR) || (paddr == STATUS_ADDR);
  assign wr_access = psel && penable && pwrite && (paddr == MODE_ADDR);
  assign rd_setup = psel && !penable && !pwrite;

  // read value of the mode register
  function automatic logic [31:0] mode_word(input logic gate, input logic det_en, input logic res);
    logic [31:0] w;
    w = 32'h0000_0000; // unused bits read as zero
    w[GATE_BIT] = gate;
    w[DET_EN_BIT] = det_en;
    w[DET_RES_BIT] = res;
    return w;
  endfunction : mode_word

  // next state
  always_comb begin
    next_st = st;

    // read data captured in setup, stands through access
    if (rd_setup) begin
      if (paddr == MODE_ADDR) begin
        next_st.rdata = mode_word(st.gate, st.det_en, st.det_result); // RULE3 RULE5
      end else if (paddr == STATUS_ADDR) begin
        next_st.rdata = {26'h000_0000, opt_det, opt_rst, st.lvr_trip, st.hold, st.mode};
      end else begin
        next_st.rdata = 32'h0000_0000;
      end
    end

    // software writes: result bit and unused bits ignored
    if (wr_access) begin
      next_st.gate = pwdata[GATE_BIT]; // RULE4
      next_st.det_en = pwdata[DET_EN_BIT]; // RULE2
    end

    // detector result follows the comparator only while powered
    next_st.det_result = det_active && lvd_low; // RULE3

    // low supply must persist before reset fires
    if (lvr_active && lvr_low) begin
      if (st.lvr_cnt == LVR_LIMIT) begin
        next_st.lvr_trip = 1'b1; // RULE8
      end else begin
        next_st.lvr_cnt = st.lvr_cnt + LVR_CNT_W'(1);
      end
    end else begin
      // short episodes are forgotten
      next_st.lvr_cnt = '0; // RULE8
      next_st.lvr_trip = 1'b0;
    end

    // settle timer after reset release
    if (st.hold) begin
      if (st.settle_cnt == SETTLE_LAST) begin
        next_st.hold = 1'b0; // RULE9
      end else begin
        next_st.settle_cnt = st.settle_cnt + SETTLE_W'(1);
      end
    end

    // operating mode transitions
    unique case (st.mode)
      MODE_NORMAL: begin
        // halt ignored until the oscillator has settled
        if (halt_exec && !st.hold) begin
          if (!st.gate) begin
            next_st.mode = MODE_IDLE; // RULE11
          end else begin
            next_st.mode = MODE_HALT; // RULE12 RULE13
          end
        end
      end
      MODE_IDLE: begin
        // wake returns to normal
        if (wake_event) begin
          next_st.mode = MODE_NORMAL; // RULE10
        end
      end
      MODE_HALT: begin
        // wake returns to normal
        if (wake_event) begin
          next_st.mode = MODE_NORMAL; // RULE10
        end
      end
    endcase

    // full chip reset restarts everything but the trip source and the read data register
    if (chip_reset) begin
      next_st.mode = MODE_NORMAL;
      next_st.gate = MODE_GATE_RST;
      next_st.det_en = MODE_DET_EN_RST;
      next_st.det_result = 1'b0;
      next_st.settle_cnt = '0;
      next_st.hold = 1'b1; // RULE9
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.mode <= MODE_NORMAL;
      st.gate <= MODE_GATE_RST;
      st.det_en <= MODE_DET_EN_RST;
      st.det_result <= 1'b0;
      st.lvr_cnt <= '0;
      st.lvr_trip <= 1'b0;
      st.settle_cnt <= '0;
      st.hold <= 1'b1;
      st.rdata <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // apb answers without wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign prdata = st.rdata;

  // block outputs
  assign startup_hold = st.hold || chip_reset; // RULE9
  assign detector_on = det_active; // RULE2
  assign op_mode = st.mode;
  // external oscillator and system clock run only in normal mode
  assign ext_osc_on = normal; // RULE10
  assign sys_clock_run = normal && !startup_hold; // RULE10
  // internal clock enabled with watchdog oscillator selected, unless in halt
  assign internal_rc_clock_en = opt_wosc && (st.mode != MODE_HALT); // RULE4 RULE14
  // oscillator runs with watchdog oscillator selected, except halt with watchdog off
  assign internal_rc_osc_on = opt_wosc && !((st.mode == MODE_HALT) && !opt_wdt); // RULE13 RULE14

  // assertions share one clock and reset
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // excluded options never act
  property p_excluded;
    (!opt_det |-> !detector_on) and (!opt_rst |-> !st.lvr_trip);
  endproperty
  a_excluded: assert property (p_excluded) else $error("excluded function acted"); // RULE1

  // detector power follows the enable bit
  property p_det_enable;
    (opt_det && normal && !chip_reset && wr_access) |=> (detector_on == $past(pwdata[DET_EN_BIT]));
  endproperty
  a_det_enable: assert property (p_det_enable) else $error("detector did not follow enable bit"); // RULE2

  // result only while detector powered and low
  property p_det_result;
    st.det_result |-> $past(detector_on) && $past(lvd_low);
  endproperty
  a_det_result: assert property (p_det_result) else $error("result bit set without detection"); // RULE3

  // reset combining
  property p_reset_or;
    (ext_reset || st.lvr_trip) |-> chip_reset && startup_hold ##1
      (st.mode == MODE_NORMAL) && !st.gate && !st.det_en && st.hold && (st.settle_cnt == '0);
  endproperty
  a_reset_or: assert property (p_reset_or) else $error("reset source did not reset chip"); // RULE6

  // power down disables monitors
  property p_power_down;
    // the count of the last normal cycle may stand for one cycle after entry
    !normal |-> (!detector_on and (!$past(normal) |-> (st.lvr_cnt == '0) && !st.lvr_trip));
  endproperty
  a_power_down: assert property (p_power_down) else $error("monitor active in power down"); // RULE7

  // trip only after the full persistence time
  property p_persist;
    $rose(st.lvr_trip) |-> ($past(st.lvr_cnt) == LVR_LIMIT) && $past(lvr_low);
  endproperty
  a_persist: assert property (p_persist) else $error("low-voltage reset fired early"); // RULE8

  // settle ends exactly after the count
  property p_settle;
    $fell(st.hold) |-> ($past(st.settle_cnt) == SETTLE_LAST) && !$past(chip_reset);
  endproperty
  a_settle: assert property (p_settle) else $error("settle delay wrong length"); // RULE9

  // halt with gate clear enters idle
  property p_idle;
    (normal && halt_exec && !st.hold && !st.gate && !chip_reset) |=> (st.mode == MODE_IDLE) && !ext_osc_on;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not entered"); // RULE11

  // halt with gate set: clock off, oscillator per watchdog
  property p_halt;
    (st.mode == MODE_HALT) |-> !internal_rc_clock_en && !sys_clock_run && (internal_rc_osc_on == (opt_wosc && opt_wdt));
  endproperty
  a_halt: assert property (p_halt) else $error("halt clock state wrong"); // RULE12 RULE13

  // oscillator needs the watchdog oscillator selection
  property p_osc_select;
    !opt_wosc |-> !internal_rc_osc_on && !internal_rc_clock_en;
  endproperty
  a_osc_select: assert property (p_osc_select) else $error("internal oscillator on without selection"); // RULE14

  // gate bit follows a software write outside reset
  property p_gate_write;
    (wr_access && !chip_reset) |=> (st.gate == $past(pwdata[GATE_BIT]));
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("halt clock gate bit missed write"); // RULE4

  // hold stays up until the settle count is complete
  property p_hold_full;
    (st.hold && (st.settle_cnt != SETTLE_LAST)) |=> st.hold;
  endproperty
  a_hold_full: assert property (p_hold_full) else $error("settle hold dropped early"); // RULE9

  // wake leaves idle or halt on the next edge
  property p_wake;
    (!normal && wake_event && !chip_reset) |=> normal;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not return to normal"); // RULE10

  // main scenarios
  property p_cov_idle;
    normal ##1 (st.mode == MODE_IDLE);
  endproperty
  c_cov_idle: cover property (p_cov_idle);

  property p_cov_halt;
    normal ##1 (st.mode == MODE_HALT);
  endproperty
  c_cov_halt: cover property (p_cov_halt);

  property p_cov_trip;
    $rose(st.lvr_trip);
  endproperty
  c_cov_trip: cover property (p_cov_trip);

  property p_cov_settle;
    $fell(st.hold);
  endproperty
  c_cov_settle: cover property (p_cov_settle);
endmodule : lvpm_top

/* verif/lvpm_tb.sv */
// Purpose: self-checking bench for the low voltage and power mode block
// Assumes: zero-wait apb slave, short persistence count for simulation
// Notes: after the time-zero values, every input but pclk is driven by non-blocking assignment at rising pclk
`timescale 1ns/10ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb;
  import lvpm_pkg::*;
  localparam int LIM = 20; // shortened low-supply persistence
  logic pclk, presetn, psel, penable, pwrite; // clock, reset, apb controls
  logic [11:0] paddr; // apb byte address
  logic [31:0] pwdata, prdata; // apb data
  logic pready, pslverr; // apb answer
  logic external_reset_pin_n, lvd_low_in, lvr_low_in; // async levels
  logic opt_detector_include, opt_reset_include, opt_watchdog_enable, watchdog_osc_select; // options
  logic halt_exec, wake_event; // mode events
  logic chip_reset, startup_hold, detector_on, ext_osc_on, sys_clock_run; // status outputs
  logic internal_rc_clock_en, internal_rc_osc_on; // internal clock controls
  lvpm_mode_type op_mode; // current operating mode
  int failures; // mismatches seen
  int samples_checked; // comparisons made

  lvpm_top #(.LVR_PERSIST_CYCLES(LIM)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(external_reset_pin_n), .lvd_low_in(lvd_low_in), .lvr_low_in(lvr_low_in),
    .opt_detector_include(opt_detector_include), .opt_reset_include(opt_reset_include),
    .opt_watchdog_enable(opt_watchdog_enable), .watchdog_osc_select(watchdog_osc_select),
    .halt_exec(halt_exec), .wake_event(wake_event), .chip_reset(chip_reset),
    .startup_hold(startup_hold), .detector_on(detector_on), .ext_osc_on(ext_osc_on),
    .sys_clock_run(sys_clock_run), .internal_rc_clock_en(internal_rc_clock_en),
    .internal_rc_osc_on(internal_rc_osc_on), .op_mode(op_mode));

  // free-running 100 MHz clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // print counts and verdict, then stop
  task automatic close_out();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // wait a number of rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // one apb transfer: setup cycle, access until pready sampled high, then release
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // register write, answer ignored
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr

  // register read compared with expected data and error flag
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp_d, input logic exp_e);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    `CHK(r, exp_d)
    `CHK(e, exp_e)
  endtask : rd_chk

  // wait for chip reset to drop, then count cycles of the settle hold
  task automatic settle_chk();
    int n;
    int c;
    n = 0;
    while (chip_reset !== 1'b0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    c = 0;
    while (startup_hold === 1'b1 && c < 2000) begin
      @(posedge pclk);
      c++;
    end
    `CHK(c, 1024)
  endtask : settle_chk

  // hold low supply for a span and count cycles with chip reset high
  task automatic low_span(input int cyc, output int n);
    lvr_low_in <= 1'b1;
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (chip_reset === 1'b1) begin
        n++;
      end
    end
    lvr_low_in <= 1'b0;
    repeat (LIM) begin
      @(posedge pclk);
      if (chip_reset === 1'b1) begin
        n++;
      end
    end
  endtask : low_span

  // one-cycle event pulse on halt or wake
  task automatic pulse(input logic h);
    @(posedge pclk);
    if (h) halt_exec <= 1'b1;
    else wake_event <= 1'b1;
    @(posedge pclk);
    halt_exec <= 1'b0;
    wake_event <= 1'b0;
    tick(1);
  endtask : pulse

  // hang guard, span well beyond the whole sequence
  initial begin : watchdog
    repeat (20000) @(posedge pclk);
    failures++;
    close_out();
  end

  // main test sequence
  initial begin : main
    int n;
    failures = 0;
    samples_checked = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {lvd_low_in, lvr_low_in, halt_exec, wake_event} = 4'h0;
    {external_reset_pin_n, opt_detector_include, opt_reset_include} = 3'b111;
    {opt_watchdog_enable, watchdog_osc_select} = 2'b11;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    settle_chk();
    `CHK(sys_clock_run, 1'b1)
    `CHK(op_mode, MODE_NORMAL)
    rd_chk(MODE_ADDR, 32'h0, 1'b0);
    wr(MODE_ADDR, 32'hffffffff);
    rd_chk(MODE_ADDR, 32'h0000000c, 1'b0);
    `CHK(detector_on, 1'b1)
    lvd_low_in <= 1'b1;
    tick(6);
    rd_chk(MODE_ADDR, 32'h0000002c, 1'b0);
    rd_chk(STATUS_ADDR, 32'h00000030, 1'b0);
    wr(MODE_ADDR, 32'h0);
    tick(2);
    `CHK(detector_on, 1'b0)
    rd_chk(MODE_ADDR, 32'h0, 1'b0);
    rd_chk(12'h100, 32'h0, 1'b1);
    // detector option excluded: enable bit has no effect
    opt_detector_include <= 1'b0;
    tick(5);
    wr(MODE_ADDR, 32'h08);
    tick(3);
    `CHK(detector_on, 1'b0)
    rd_chk(MODE_ADDR, 32'h08, 1'b0);
    opt_detector_include <= 1'b1;
    lvd_low_in <= 1'b0;
    // idle, halt with watchdog, halt without watchdog
    for (int i = 0; i < 3; i++) begin
      opt_watchdog_enable <= (i != 2);
      tick(5);
      wr(MODE_ADDR, (i == 0) ? 32'h08 : 32'h0c);
      pulse(1'b1);
      `CHK(op_mode, (i == 0) ? MODE_IDLE : MODE_HALT)
      `CHK({ext_osc_on, sys_clock_run}, 2'b00)
      `CHK(internal_rc_clock_en, i == 0)
      `CHK(internal_rc_osc_on, i != 2)
      `CHK(detector_on, 1'b0)
      pulse(1'b0);
      `CHK({op_mode, ext_osc_on, internal_rc_clock_en}, {MODE_NORMAL, 2'b11})
    end
    // internal oscillator needs the watchdog oscillator selection
    watchdog_osc_select <= 1'b0;
    tick(5);
    `CHK({internal_rc_osc_on, internal_rc_clock_en}, 2'b00)
    watchdog_osc_select <= 1'b1;
    tick(5);
    // short low-supply episode is ignored
    low_span(LIM / 2, n);
    `CHK(n, 0)
    // low-supply monitor is off in idle
    wr(MODE_ADDR, 32'h0);
    pulse(1'b1);
    low_span(LIM + 20, n);
    `CHK(n, 0)
    pulse(1'b0);
    // reset option excluded: no trip at all
    opt_reset_include <= 1'b0;
    tick(5);
    low_span(LIM + 20, n);
    `CHK(n, 0)
    opt_reset_include <= 1'b1;
    tick(5);
    // long episode trips after the persistence count
    wr(MODE_ADDR, 32'h0c);
    lvr_low_in <= 1'b1;
    n = 0;
    while (chip_reset !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n > LIM, 1'b1)
    `CHK(n < LIM + 8, 1'b1)
    lvr_low_in <= 1'b0;
    settle_chk();
    rd_chk(MODE_ADDR, 32'h0, 1'b0);
    // external reset pin gives the same chip reset
    wr(MODE_ADDR, 32'h0c);
    external_reset_pin_n <= 1'b0;
    tick(6);
    `CHK({chip_reset, startup_hold}, 2'b11)
    external_reset_pin_n <= 1'b1;
    settle_chk();
    rd_chk(MODE_ADDR, 32'h0, 1'b0);
    close_out();
  end
endmodule : tb
